/* File: pkg/eap_pkg.sv */
// package: register map, opcodes, timing and state types of the eeprom access block
package eap_pkg;
    // clock rate
    localparam int CLK_PERIOD_NS = 100;                // pclk period, 10 mhz
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_BYTE_BUFFER = 8'h20;   // eeprom_byte_buffer
    localparam logic [7:0]  IDX_LOCATION    = 8'h21;   // eeprom_location_select
    localparam logic [7:0]  IDX_TRIGGER     = 8'h22;   // eeprom_operation_trigger
    localparam logic [7:0]  IDX_STATUS      = 8'h23;   // eeprom_status_reg
    // reset values
    localparam logic [7:0]  LOC_RESET       = 8'h00;   // location select after reset
    localparam logic [7:0]  BUF_RESET       = 8'h00;   // byte buffer after reset
    localparam logic [7:0]  MEM_ERASED      = 8'hff;   // array content after reset
    // operation codes
    localparam logic [7:0]  OPC_READ        = 8'h01;   // fetch one byte
    localparam logic [7:0]  OPC_PROGRAM     = 8'h02;   // store one byte
    // status bit positions
    localparam int          STAT_RD_BUSY    = 0;       // read in progress
    localparam int          STAT_PG_BUSY    = 1;       // programming in progress
    // array timing
    localparam int          READ_TIME_NS    = 1000;    // read access time
    localparam int          PROG_TIME_NS    = 100000;  // programming time
    localparam logic [9:0]  READ_CYC  =
        10'((READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0]  PROG_CYC  =
        10'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // access sequencer states, one bit away from idle for either access
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_PROG = 2'b10
    } eap_state_t;

    // apb request bundle
    typedef struct packed
    {
        logic [11:0] paddr;     // byte address
        logic        psel;      // slave select
        logic        penable;   // access phase
        logic        pwrite;    // write direction
        logic [31:0] pwdata;    // write data
    } eap_apb_req_t;

    // apb answer bundle
    typedef struct packed
    {
        logic [31:0] prdata;    // read data
        logic        pready;    // transfer done
        logic        pslverr;   // unmapped address
    } eap_apb_rsp_t;

    // whole block state
    typedef struct packed
    {
        eap_state_t             st;       // sequencer
        logic [9:0]             cnt;      // cycles left in access
        logic [7:0]             loc;      // eeprom_location_select
        logic [7:0]             buf8;     // eeprom_byte_buffer
        logic                   busy;     // access_in_progress_flag
        eap_apb_rsp_t           rsp;      // registered bus answer
        logic [255:0][7:0]      mem;      // eeprom array
    } eap_regs_t;
endpackage : eap_pkg

/* File: rtl/eap_regs.sv */
// eeprom access registers: apb slave, access sequencer and eeprom array
// What this block does
// [RULE_01] software loads data before program eeprom_operation_code
// [RULE_02] finished read copies stored byte into buffer
// [RULE_03] software leaves data register alone while busy
// [RULE_04] software loads location before any eeprom_operation_code
// [RULE_05] software leaves location register alone while busy
// [RULE_06] location register at 0x21, eight bits, resets 0x00
// [RULE_07] eeprom_operation_code register writable at 0x22
// [RULE_08] data register eight bits, resets 0x00
// [RULE_09] eeprom_operation_code write launches access, busy until done
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module eap_regs
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire eap_pkg::eap_apb_req_t apb_req,
    output eap_pkg::eap_apb_rsp_t      apb_rsp,
    output logic                       access_in_progress_flag
);
    import eap_pkg::*;

    // true when a byte address hits a register index
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
    endfunction : hit

    eap_regs_t st_r;                 // registered state
    eap_regs_t st_nxt;               // next state
    logic      setup;                // apb setup phase
    logic      wr_done;              // write completes at this edge
    logic      mapped;               // address names a register
    logic [7:0] stored_byte;         // array byte at current location
    logic [7:0] opc;                 // eeprom_operation_code written this cycle

    // bus phase decode
    assign setup       = apb_req.psel & ~apb_req.penable;
    assign wr_done     = apb_req.psel & apb_req.penable & st_r.rsp.pready & apb_req.pwrite;
    assign mapped      = hit(apb_req.paddr, IDX_BYTE_BUFFER) | hit(apb_req.paddr, IDX_LOCATION)
                       | hit(apb_req.paddr, IDX_TRIGGER) | hit(apb_req.paddr, IDX_STATUS);
    assign stored_byte = st_r.mem[st_r.loc];
    assign opc         = apb_req.pwdata[7:0];

    // next-state logic: bus slave, register writes and sequencer
    always_comb
    begin
        st_nxt = st_r;
        // answer one cycle after setup, so every access phase is one cycle
        st_nxt.rsp.pready  = setup;
        st_nxt.rsp.pslverr = setup & ~mapped;
        st_nxt.rsp.prdata  = 32'h0000_0000;
        if (setup && !apb_req.pwrite)
        begin
            // read mux; write-only trigger reads as zero
            if (hit(apb_req.paddr, IDX_BYTE_BUFFER))
                st_nxt.rsp.prdata = {24'h00_0000, st_r.buf8};
            else if (hit(apb_req.paddr, IDX_LOCATION))
                st_nxt.rsp.prdata = {24'h00_0000, st_r.loc};
            else if (hit(apb_req.paddr, IDX_STATUS))
            begin
                st_nxt.rsp.prdata[STAT_RD_BUSY] = (st_r.st == ST_READ);
                st_nxt.rsp.prdata[STAT_PG_BUSY] = (st_r.st == ST_PROG);
            end
        end
        case (st_r.st)
            ST_IDLE:
            begin
                // register writes are accepted only while idle
                if (wr_done && hit(apb_req.paddr, IDX_LOCATION))
                    st_nxt.loc = opc;                        // see [RULE_06]
                if (wr_done && hit(apb_req.paddr, IDX_BYTE_BUFFER))
                    st_nxt.buf8 = opc;                       // see [RULE_08]
                if (wr_done && hit(apb_req.paddr, IDX_TRIGGER))
                begin
                    // launch on a known eeprom_operation_code; others are ignored
                    if (opc == OPC_READ)
                    begin
                        st_nxt.st  = ST_READ;                // see [RULE_07]
                        st_nxt.cnt = READ_CYC - 10'h001;     // see [RULE_09]
                    end
                    else if (opc == OPC_PROGRAM)
                    begin
                        st_nxt.st  = ST_PROG;                // see [RULE_07]
                        st_nxt.cnt = PROG_CYC - 10'h001;     // see [RULE_09]
                    end
                end
            end
            ST_READ:
            begin
                // count down; on the last cycle fetch into the buffer
                if (st_r.cnt == 10'h000)
                begin
                    st_nxt.buf8 = stored_byte;               // see [RULE_02]
                    st_nxt.st   = ST_IDLE;
                end
                else
                    st_nxt.cnt = st_r.cnt - 10'h001;
            end
            ST_PROG:
            begin
                // buffer and location are frozen, so store at the end
                if (st_r.cnt == 10'h000)
                begin
                    st_nxt.mem[st_r.loc] = st_r.buf8;        // see [RULE_01]
                    st_nxt.st            = ST_IDLE;
                end
                else
                    st_nxt.cnt = st_r.cnt - 10'h001;
            end
            default:
            begin
                // illegal code recovers to idle
                st_nxt.st = ST_IDLE;
            end
        endcase
        // busy mirrors the sequencer from the same edge
        st_nxt.busy = (st_nxt.st != ST_IDLE);                // see [RULE_09]
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r      <= '0;
            st_r.st   <= ST_IDLE;
            st_r.loc  <= LOC_RESET;                          // see [RULE_06]
            st_r.buf8 <= BUF_RESET;                          // see [RULE_08]
            st_r.mem  <= {256{MEM_ERASED}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign apb_rsp                 = st_r.rsp;
    assign access_in_progress_flag = st_r.busy;

    // a finished read leaves the stored byte in the buffer
    AST_READ_FILLS_BUFFER: assert property (  // see [RULE_02]
        @(posedge pclk) disable iff (!presetn)
        (st_r.st == ST_READ && st_r.cnt == 10'h000) |=> (st_r.buf8 == $past(stored_byte)))
        else $error("read did not load the byte buffer");

    // location write while idle lands in the location register
    AST_LOCATION_WRITE: assert property (  // see [RULE_06]
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit(apb_req.paddr, IDX_LOCATION) && st_r.st == ST_IDLE)
        |=> (st_r.loc == $past(apb_req.pwdata[7:0])))
        else $error("location register missed a write");

    // buffer write while idle lands in the byte buffer
    AST_BUFFER_WRITE: assert property (  // see [RULE_08]
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit(apb_req.paddr, IDX_BYTE_BUFFER) && st_r.st == ST_IDLE)
        |=> (st_r.buf8 == $past(apb_req.pwdata[7:0])))
        else $error("byte buffer missed a write");

    // program eeprom_operation_code at the trigger starts programming and raises busy
    AST_TRIGGER_LAUNCH: assert property (  // see [RULE_07]
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit(apb_req.paddr, IDX_TRIGGER) && st_r.st == ST_IDLE
         && apb_req.pwdata[7:0] == OPC_PROGRAM)
        |=> (st_r.st == ST_PROG) && access_in_progress_flag)
        else $error("program eeprom_operation_code did not launch");

    // a read holds busy for exactly the read time
    AST_READ_BUSY_SPAN: assert property (  // see [RULE_09]
        @(posedge pclk) disable iff (!presetn)
        ($rose(access_in_progress_flag) && st_r.st == ST_READ)
        |-> access_in_progress_flag [*8] ##1 access_in_progress_flag
            ##1 access_in_progress_flag ##1 !access_in_progress_flag)
        else $error("read busy span is not ten cycles");

    // programming stores the buffer at the selected location
    AST_PROGRAM_STORES: assert property (  // see [RULE_01]
        @(posedge pclk) disable iff (!presetn)
        (st_r.st == ST_PROG && st_r.cnt == 10'h000) |=> (stored_byte == $past(st_r.buf8)))
        else $error("programming did not store the buffer");

    // every setup phase is answered in the next cycle
    AST_APB_ANSWER: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup |=> apb_rsp.pready)
        else $error("apb setup not answered");

    // main scenarios
    COV_READ_DONE: cover property (
        @(posedge pclk) disable iff (!presetn)
        st_r.st == ST_READ ##1 st_r.st == ST_IDLE);
    COV_PROG_DONE: cover property (
        @(posedge pclk) disable iff (!presetn)
        st_r.st == ST_PROG ##1 st_r.st == ST_IDLE);
    COV_UNMAPPED: cover property (
        @(posedge pclk) disable iff (!presetn)
        apb_rsp.pready && apb_rsp.pslverr);
    COV_WRITE_WHILE_BUSY: cover property (
        @(posedge pclk) disable iff (!presetn)
        wr_done && access_in_progress_flag);

    // read eeprom_operation_code at the trigger starts a read and raises busy
    AST_READ_LAUNCH: assert property (  // see [RULE_07]
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit(apb_req.paddr, IDX_TRIGGER) && st_r.st == ST_IDLE
         && apb_req.pwdata[7:0] == OPC_READ)
        |=> (st_r.st == ST_READ) && access_in_progress_flag)
        else $error("read eeprom_operation_code did not launch");

    // the location stays put while an access runs
    AST_LOCATION_FROZEN: assert property (  // see [RULE_06]
        @(posedge pclk) disable iff (!presetn)
        (st_r.st != ST_IDLE) |=> (st_r.loc == $past(st_r.loc)))
        else $error("location changed during an access");

    // busy flag and sequencer agree in every cycle
    AST_BUSY_MATCHES_STATE: assert property (  // see [RULE_09]
        @(posedge pclk) disable iff (!presetn)
        access_in_progress_flag == (st_r.st != ST_IDLE))
        else $error("busy flag disagrees with the sequencer");

    // read data is quiet outside the answer cycle
    AST_PRDATA_QUIET: assert property (
        @(posedge pclk) disable iff (!presetn)
        !apb_rsp.pready |-> (apb_rsp.prdata == 32'h0000_0000))
        else $error("read data not zero outside an answer");
endmodule : eap_regs

/* File: verif/eap_regs_tb_top.sv */
// testbench for the eeprom access registers: apb table, access timing, busy drops, reset
`timescale 1ns/1ps
module eap_regs_tb_top;
    import eap_pkg::*;
    // one table row: transfer and the answer it should give
    typedef struct packed
    {
        logic        w;     // write direction
        logic [11:0] a;     // byte address
        logic [31:0] d;     // write data
        logic [31:0] q;     // expected read data
        logic        e;     // expected error flag
    } eap_tb_row_t;
    logic          pclk;        // bus clock
    logic          presetn;     // async reset, active low
    eap_apb_req_t  req;         // bus request
    eap_apb_rsp_t  rsp;         // bus answer
    logic          busy;        // access running
    int            fail_count;  // mismatches
    int            compares;    // comparisons made
    int            cyc;         // timeout counter
    int            busy_len;    // cycles with busy high
    logic [31:0]   q;           // read data taken
    logic          e;           // error flag taken
    eap_tb_row_t   rows [9];    // ordinary cases
    eap_regs eap_regs_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .access_in_progress_flag(busy));
    // clock at 100 ns period
    initial
    begin
        pclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
    end
    // hang guard and busy length counter
    always @(posedge pclk)
    begin
        cyc++;
        if (busy === 1'b1) busy_len++;
        if (cyc == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    // compare seen against expected
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        q = rsp.prdata;
        e = rsp.pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    // read one register and compare
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd_chk
    // bounded wait for the access to finish
    task automatic wait_idle();
        int n;
        n = 0;
        // let the launching edge settle before busy is looked at
        @(posedge pclk);
        while (busy !== 1'b0 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_idle
    // closing verdict
    task automatic final_report();
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // main sequence
    initial
    begin
        req = '0;
        presetn = 1'b0;
        fail_count = 0;
        compares = 0;
        cyc = 0;
        busy_len = 0;
        rows[0] = '{1'b1, 12'h084, 32'h000000a5, 32'h0, 1'b0};
        rows[1] = '{1'b0, 12'h084, 32'h0, 32'h000000a5, 1'b0};
        rows[2] = '{1'b1, 12'h080, 32'hffffff3c, 32'h0, 1'b0};
        rows[3] = '{1'b0, 12'h080, 32'h0, 32'h0000003c, 1'b0};
        rows[4] = '{1'b0, 12'h088, 32'h0, 32'h0, 1'b0};
        rows[5] = '{1'b1, 12'h088, 32'h00000007, 32'h0, 1'b0};
        rows[6] = '{1'b0, 12'h08c, 32'h0, 32'h0, 1'b0};
        rows[7] = '{1'b1, 12'h090, 32'h00000055, 32'h0, 1'b1};
        rows[8] = '{1'b0, 12'h086, 32'h0, 32'h0, 1'b1};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(12'h084, 32'h0);
        rd_chk(12'h080, 32'h0);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (rows[i].w == 1'b0) chk(q, rows[i].q);
            chk({31'h0, e}, {31'h0, rows[i].e});
        end
        // program 0x5a at location 0x12, busy writes dropped meanwhile
        apb(1'b1, 12'h084, 32'h12);
        apb(1'b1, 12'h080, 32'h5a);
        busy_len = 0;
        apb(1'b1, 12'h088, {24'h0, OPC_PROGRAM});
        #1 chk({31'h0, busy}, 32'h1);
        rd_chk(12'h08c, 32'h2);
        apb(1'b1, 12'h080, 32'h11);
        wait_idle();
        chk(32'(busy_len), 32'(PROG_CYC));
        rd_chk(12'h080, 32'h5a);
        // read back after clearing buffer, location write while busy dropped
        apb(1'b1, 12'h080, 32'h0);
        busy_len = 0;
        apb(1'b1, 12'h088, {24'h0, OPC_READ});
        rd_chk(12'h08c, 32'h1);
        apb(1'b1, 12'h084, 32'h33);
        wait_idle();
        chk(32'(busy_len), 32'(READ_CYC));
        rd_chk(12'h080, 32'h5a);
        rd_chk(12'h084, 32'h12);
        // mid-run reset restores registers and erased array
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(12'h084, 32'h0);
        rd_chk(12'h080, 32'h0);
        apb(1'b1, 12'h084, 32'h12);
        apb(1'b1, 12'h088, {24'h0, OPC_READ});
        wait_idle();
        rd_chk(12'h080, {24'h0, MEM_ERASED});
        final_report();
    end
endmodule : eap_regs_tb_top
